// [dv/fpio_far_end.sv]
// Purpose: far-side model of boards wired to the differential pins
// Assumes: the far end drives every pin the block leaves undriven
// Notes: driven pins show the block's own level on the wire
`timescale 1ns/100ps
`default_nettype none
module fpio_far_end (
   input wire logic [15:0] diff_out, // block drive levels
   input wire logic [15:0] diff_oe_n, // low where the block drives
   input wire logic [15:0] far_level, // levels the far boards drive
   output logic [15:0] diff_in // resolved wire levels
);
   // a pin is never left floating: one side always owns it
   assign diff_in = (diff_out & ~diff_oe_n) | (far_level & diff_oe_n);
endmodule
`default_nettype wire

// [dv/test_fpio_ctrl.sv]
// Purpose: self-checking bench for the front-panel I/O control block
// Assumes: one-cycle read answer, writes visible on the next cycle
// Notes: inputs move 1 ns after the rising edge
`timescale 1ns/100ps
`default_nettype none
module test_fpio_ctrl;
   localparam logic [15:0] A_PIN = fpio_pkg::FPIO_DIFF_PIN_LEVEL_OFS;
   localparam logic [15:0] A_CTL = fpio_pkg::FPIO_FRONT_PANEL_IO_CTRL_OFS;
   localparam logic [15:0] A_DAC = fpio_pkg::FPIO_MONITOR_DAC_LEVEL_OFS;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   fpio_pkg::fpio_reg_req_t req = '0;
   fpio_pkg::fpio_reg_rsp_t rsp;
   fpio_pkg::fpio_probe_t probes = '0;
   logic [15:0] diff_in, diff_out, diff_oe_n, pattern;
   logic [15:0] far_level = 16'h0000;
   logic [15:0] prog_out = 16'h0000;
   logic [15:0] prog_dir = 16'h0000;
   logic [3:0] new_mode = 4'h0;
   logic trig_in = 1'b0;
   logic gtrig = 1'b0;
   logic ext_trig = 1'b0;
   logic [7:0] pair_req = 8'h00;
   logic [7:0] out_mask = 8'h00;
   logic [1:0] out_logic = 2'h0;
   logic [2:0] maj = 3'h1;
   logic [2:0] mon_mode = 3'h0;
   logic board_trig, level_ttl, trig_out, trig_oe_n, dac_en;
   logic [11:0] dac_code;
   int failures = 0;
   int cmp_count = 0;
   always #4 core_clk = ~core_clk;
   fpio_ctrl i_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_req(req), .reg_rsp(rsp),
      .diff_in(diff_in), .diff_out(diff_out), .diff_oe_n(diff_oe_n),
      .new_cfg_mode(new_mode), .prog_out(prog_out), .prog_dir(prog_dir),
      .trigger_input(trig_in), .board_trig(board_trig), .level_ttl(level_ttl),
      .gtrig_to_chan(gtrig), .ext_trig_arrive(ext_trig), .pattern(pattern),
      .pair_trig_req(pair_req), .out_mask(out_mask), .out_logic(out_logic),
      .out_maj_level(maj), .probes(probes), .trigger_output(trig_out),
      .trigger_output_oe_n(trig_oe_n), .monitor_mode(mon_mode),
      .monitor_dac_code(dac_code), .monitor_dac_en(dac_en));
   fpio_far_end i_far (.diff_out(diff_out), .diff_oe_n(diff_oe_n),
      .far_level(far_level), .diff_in(diff_in));
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      tick(1);
      req.wr = 1'b0;
      tick(1);
   endtask
   task automatic rd_reg(input logic [15:0] a, input logic [31:0] exp);
      req.rd = 1'b1;
      req.addr = a;
      tick(1);
      req.rd = 1'b0;
      chk({31'h0, rsp.ack}, 32'h1);
      chk(rsp.data, exp);
      tick(1);
   endtask
   // write followed at once by a read of the same address, back to back
   task automatic wr_rd(input logic [15:0] a, input logic [31:0] d, input logic [31:0] exp);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      tick(1);
      req.wr = 1'b0;
      req.rd = 1'b1;
      tick(1);
      req.rd = 1'b0;
      chk({31'h0, rsp.ack}, 32'h1);
      chk(rsp.data, exp);
      tick(1);
   endtask
   task automatic t_reset;
      chk(diff_oe_n, 16'hffff);
      chk({trig_oe_n, level_ttl}, 2'b00);
      rd_reg(A_CTL, 32'h0);
   endtask
   task automatic t_regs;
      wr_rd(A_CTL, 32'hffff_ffff, 32'h007f_cfff);
      chk(level_ttl, 1'b1);
      chk(trig_oe_n, 1'b1);
      wr_rd(A_DAC, 32'hffff_f5a5, 32'h0000_05a5);
      chk(dac_code, 12'h5a5);
      mon_mode = 3'h4;
      tick(1);
      chk(dac_en, 1'b1);
      mon_mode = 3'h3;
      tick(1);
      chk(dac_en, 1'b0);
      rd_reg(16'h8120, 32'h0);
      wr_reg(A_CTL, 32'h0);
   endtask
   task automatic t_pins;
      far_level = 16'h3c3c;
      wr_reg(A_CTL, 32'h0000_0004);
      chk(diff_oe_n, 16'hfff0);
      wr_reg(A_CTL, 32'h0000_0014);
      wr_reg(A_PIN, 32'hffff_a5c3);
      chk(diff_oe_n, 16'hf0f0);
      chk(diff_out & 16'h0f0f, 16'h0503);
      rd_reg(A_PIN, 32'h0000_3533);
      wr_reg(A_CTL, 32'h0000_0094);
      chk(diff_oe_n, 16'hffff);
      prog_dir = 16'h00ff;
      prog_out = 16'h0055;
      wr_reg(A_CTL, 32'h0000_0054);
      chk(diff_oe_n, 16'hff00);
      chk(diff_out & 16'h00ff, 16'h0055);
      wr_reg(A_CTL, 32'h0000_01d4);
      chk(diff_oe_n, 16'hf0f0);
      new_mode = 4'h1;
      tick(1);
      chk(diff_oe_n, 16'hffff);
      new_mode = 4'h0;
      wr_reg(A_CTL, 32'h0);
   endtask
   task automatic t_trig_in;
      trig_in = 1'b1;
      tick(1);
      chk(board_trig, 1'b1);
      tick(1);
      chk(board_trig, 1'b0);
      trig_in = 1'b0;
      wr_reg(A_CTL, 32'h0000_0400);
      trig_in = 1'b1;
      tick(2);
      chk(board_trig, 1'b1);
      trig_in = 1'b0;
      tick(1);
      chk(board_trig, 1'b0);
      wr_reg(A_CTL, 32'h0000_0c00);
      trig_in = 1'b1;
      tick(1);
      chk(board_trig, 1'b1);
      trig_in = 1'b0;
      tick(1);
      chk(board_trig, 1'b0);
      tick(1);
   endtask
   task automatic pulse(input logic use_ext);
      gtrig = !use_ext;
      ext_trig = use_ext;
      tick(1);
      gtrig = 1'b0;
      ext_trig = 1'b0;
      tick(1);
   endtask
   task automatic t_pattern;
      wr_reg(A_CTL, 32'h0);
      far_level = 16'hbeef;
      pulse(1'b0);
      chk(pattern, 16'hbeef);
      far_level = 16'h1234;
      pulse(1'b1);
      chk(pattern, 16'hbeef);
      wr_reg(A_CTL, 32'h0000_0200);
      pulse(1'b0);
      chk(pattern, 16'hbeef);
      pulse(1'b1);
      chk(pattern, 16'h1234);
      wr_reg(A_CTL, 32'h0020_0200);
      pulse(1'b1);
      chk(pattern, 16'h0);
   endtask
   task automatic t_trig_out;
      logic [31:0] sel [8];
      logic [10:0] cmb [7];
      sel = '{32'h0001_0000, 32'h0011_0000, 32'h0005_0000, 32'h0009_0000,
         32'h000d_0000, 32'h001d_0000, 32'h0002_0000, 32'h0003_0000};
      // entries: logic code, requests, expected output with pairs 0-3 enabled
      cmb = '{{2'h0, 8'h10, 1'b0}, {2'h0, 8'h04, 1'b1}, {2'h1, 8'h0f, 1'b1},
         {2'h1, 8'h8e, 1'b0}, {2'h2, 8'h03, 1'b1}, {2'h2, 8'h21, 1'b0},
         {2'h3, 8'h0f, 1'b0}};
      wr_reg(A_CTL, 32'h0000_c000);
      tick(2);
      chk(trig_out, 1'b1);
      probes = '1;
      wr_reg(A_CTL, 32'h0003_8000);
      tick(2);
      chk(trig_out, 1'b0);
      for (int i = 0; i < 8; i++) begin
         wr_reg(A_CTL, sel[i]);
         probes = fpio_pkg::fpio_probe_t'(8'h80 >> i);
         tick(3);
         chk(trig_out, 1'b1);
         probes = fpio_pkg::fpio_probe_t'(~(8'h80 >> i));
         tick(3);
         chk(trig_out, 1'b0);
      end
      wr_reg(A_CTL, 32'h0);
      out_mask = 8'h0f;
      for (int i = 0; i < 7; i++) begin
         out_logic = cmb[i][10:9];
         pair_req = cmb[i][8:1];
         tick(2);
         chk(trig_out, cmb[i][0]);
      end
   endtask
   task automatic final_report;
      $display("failures %0d compares %0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      tick(8);
      rst_n = 1'b1;
      t_reset;
      t_regs;
      t_pins;
      t_trig_in;
      t_pattern;
      t_trig_out;
      // a second reset in mid-run must clear the control register again
      wr_reg(A_CTL, 32'h0000_00ff);
      rst_n = 1'b0;
      tick(2);
      rst_n = 1'b1;
      tick(1);
      t_reset;
      final_report;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      failures++;
      final_report;
   end
endmodule
`default_nettype wire

// [hw/fpio_ctrl.sv]
// Purpose: front-panel I/O control: differential pins, trigger in/out, pattern, monitor DAC
// Assumes: all inputs except the asynchronous rst_n synchronous to core_clk; registers reached by the word register port
// Notes: pins are split into input, output and active-low output enable
`timescale 1ns/100ps
`default_nettype none

module fpio_ctrl #(
   parameter int NUM_PINS = 16,
   parameter int NUM_PAIRS = 8,
   parameter int GROUP_SIZE = 4
) (
   input wire logic core_clk, // board clock, 125 MHz
   input wire logic rst_n, // asynchronous reset, active low
   input wire fpio_pkg::fpio_reg_req_t reg_req, // register write/read request
   output fpio_pkg::fpio_reg_rsp_t reg_rsp, // read answer, one cycle later
   input wire logic [NUM_PINS-1:0] diff_in, // differential pin levels seen
   output logic [NUM_PINS-1:0] diff_out, // differential pin drive levels
   output logic [NUM_PINS-1:0] diff_oe_n, // low where a pin is driven
   input wire logic [3:0] new_cfg_mode, // new-features mode from its own register
   input wire logic [NUM_PINS-1:0] prog_out, // fixed-function pin levels
   input wire logic [NUM_PINS-1:0] prog_dir, // fixed-function pin directions
   input wire logic trigger_input, // trigger input connector level
   output logic board_trig, // trigger toward the channels
   output logic level_ttl, // connector standard, 1 = TTL
   input wire logic gtrig_to_chan, // internal global trigger reaches channels
   input wire logic ext_trig_arrive, // external trigger arrival pulse
   output logic [NUM_PINS-1:0] pattern, // event header pattern
   input wire logic [NUM_PAIRS-1:0] pair_trig_req, // channel-pair trigger requests
   input wire logic [NUM_PAIRS-1:0] out_mask, // enabled pairs for the output
   input wire logic [1:0] out_logic, // combine logic, OR/AND/majority
   input wire logic [2:0] out_maj_level, // majority level m, fires at m+1
   input wire fpio_pkg::fpio_probe_t probes, // internal probe signals
   output logic trigger_output, // trigger output connector level
   output logic trigger_output_oe_n, // low while trigger output is driven
   input wire logic [2:0] monitor_mode, // monitor output mode
   output logic [11:0] monitor_dac_code, // DAC code for monitor output
   output logic monitor_dac_en // monitor output follows the DAC code
);

   logic [31:0] ctrl_q, ctrl_d;
   logic [NUM_PINS-1:0] pin_q, pin_d;
   logic [11:0] dac_q, dac_d;
   logic [NUM_PINS-1:0] pin_seen_q, pin_seen_d;
   logic [NUM_PINS-1:0] pat_q, pat_d;
   logic trig_prev_q, trig_prev_d;
   logic trig_q, trig_d;
   logic run_q, run_d;
   logic tout_q, tout_d;
   fpio_pkg::fpio_reg_rsp_t rsp_q, rsp_d;
   logic [NUM_PINS-1:0] drv_en, pin_drive, pin_read;
   logic reg_mode, sel_ctrl, sel_pin, sel_dac;
   logic [1:0] sig_cfg, out_src, probe_sel;
   logic [NUM_PAIRS-1:0] req_on;
   logic comb_trig, probe_val;

   function automatic logic [3:0] count_ones(input logic [NUM_PAIRS-1:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < NUM_PAIRS; i++) begin
         n = n + {3'h0, v[i]};
      end
      return n;
   endfunction

   assign sel_ctrl = reg_req.addr == fpio_pkg::FPIO_FRONT_PANEL_IO_CTRL_OFS;
   assign sel_pin = reg_req.addr == fpio_pkg::FPIO_DIFF_PIN_LEVEL_OFS;
   assign sel_dac = reg_req.addr == fpio_pkg::FPIO_MONITOR_DAC_LEVEL_OFS;
   assign sig_cfg = ctrl_q[fpio_pkg::FPIO_SIG_CFG_LSB +: 2];
   assign out_src = ctrl_q[fpio_pkg::FPIO_OUT_SRC_LSB +: 2];
   assign probe_sel = ctrl_q[fpio_pkg::FPIO_PROBE_LSB +: 2];

   // register mode: the only case where the pin data register owns the pins
   always_comb begin
      if (ctrl_q[fpio_pkg::FPIO_NEW_FEAT_BIT]) begin
         reg_mode = new_cfg_mode == fpio_pkg::FPIO_NEW_REGISTER_MODE;
      end else begin
         reg_mode = sig_cfg == fpio_pkg::FPIO_SIG_GENERAL;
      end
   end

   // per-pin direction and drive source
   for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
      always_comb begin
         drv_en[g] = 1'b0;
         pin_drive[g] = 1'b0;
         if (reg_mode) begin
            drv_en[g] = ctrl_q[fpio_pkg::FPIO_DIR_LSB + g / GROUP_SIZE];
            pin_drive[g] = pin_q[g];
         end else if (!ctrl_q[fpio_pkg::FPIO_NEW_FEAT_BIT]
                      && sig_cfg == fpio_pkg::FPIO_SIG_PROGRAMMED) begin
            drv_en[g] = prog_dir[g];
            pin_drive[g] = prog_out[g];
         end
         // with new features off, pattern mode and the reserved code leave every pin undriven
         pin_read[g] = drv_en[g] ? pin_q[g] : pin_seen_q[g];
      end
   end

   assign diff_out = pin_drive;
   assign diff_oe_n = ~drv_en;

   // register file
   always_comb begin
      ctrl_d = ctrl_q;
      pin_d = pin_q;
      dac_d = dac_q;
      rsp_d = '0;
      if (reg_req.wr && sel_ctrl) begin
         ctrl_d = reg_req.wdata & fpio_pkg::FPIO_CTRL_WMASK;
      end
      if (reg_req.wr && sel_pin) begin
         pin_d = reg_req.wdata[NUM_PINS-1:0];
      end
      if (reg_req.wr && sel_dac) begin
         dac_d = reg_req.wdata[11:0];
      end
      if (reg_req.rd) begin
         rsp_d.ack = 1'b1;
         if (sel_ctrl) begin
            rsp_d.data = ctrl_q;
         end else if (sel_pin) begin
            rsp_d.data = {{(32-NUM_PINS){1'b0}}, pin_read};
         end else if (sel_dac) begin
            rsp_d.data = {20'h0_0000, dac_q};
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= fpio_pkg::FPIO_CTRL_RESET;
         pin_q <= fpio_pkg::FPIO_PIN_RESET;
         dac_q <= fpio_pkg::FPIO_DAC_RESET;
         rsp_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         pin_q <= pin_d;
         dac_q <= dac_d;
         rsp_q <= rsp_d;
      end
   end

   assign reg_rsp = rsp_q;
   assign level_ttl = ctrl_q[fpio_pkg::FPIO_LEVEL_TTL_BIT];

   // pattern capture and trigger input conditioning
   always_comb begin
      pin_seen_d = diff_in;
      pat_d = pat_q;
      if (ctrl_q[fpio_pkg::FPIO_LATCH_EXT_BIT] ? ext_trig_arrive : gtrig_to_chan) begin
         if (ctrl_q[fpio_pkg::FPIO_PAT_CFG_LSB +: 2] == fpio_pkg::FPIO_PAT_PINS) begin
            pat_d = diff_in;
         end else begin
            pat_d = '0;
         end
      end
      trig_prev_d = trigger_input;
      // edge mode gives a one-cycle pulse, level mode follows the whole duration
      if (ctrl_q[fpio_pkg::FPIO_TRIG_LEVEL_BIT]) begin
         trig_d = trigger_input;
      end else begin
         trig_d = trigger_input & ~trig_prev_q;
      end
      run_d = probes.run;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_seen_q <= '0;
         pat_q <= '0;
         trig_prev_q <= 1'b0;
         trig_q <= 1'b0;
         run_q <= 1'b0;
      end else begin
         pin_seen_q <= pin_seen_d;
         pat_q <= pat_d;
         trig_prev_q <= trig_prev_d;
         trig_q <= trig_d;
         run_q <= run_d;
      end
   end

   assign pattern = pat_q;
   // direct path has no flop on purpose: it is used as a veto and must not lag
   assign board_trig = ctrl_q[fpio_pkg::FPIO_TRIG_DIRECT_BIT] ? trigger_input : trig_q;

   // trigger output source selection
   assign req_on = pair_trig_req & out_mask;
   always_comb begin
      case (out_logic)
         fpio_pkg::FPIO_LOGIC_OR: comb_trig = |req_on;
         fpio_pkg::FPIO_LOGIC_AND: comb_trig = (|out_mask) && (req_on == out_mask);
         fpio_pkg::FPIO_LOGIC_MAJ: comb_trig = count_ones(req_on) > {1'b0, out_maj_level};
         default: comb_trig = 1'b0;
      endcase
      case (probe_sel)
         fpio_pkg::FPIO_PROBE_RUN: begin
            probe_val = ctrl_q[fpio_pkg::FPIO_PROBE_ALT_BIT] ? probes.delayed_run : run_q;
         end
         fpio_pkg::FPIO_PROBE_SCLK: probe_val = probes.sampling_clock;
         fpio_pkg::FPIO_PROBE_PHASE: probe_val = probes.clock_phase;
         fpio_pkg::FPIO_PROBE_BUSY: begin
            probe_val = ctrl_q[fpio_pkg::FPIO_PROBE_ALT_BIT] ? probes.pll_lock_loss : probes.busy;
         end
         default: probe_val = 1'b0;
      endcase
      if (ctrl_q[fpio_pkg::FPIO_FORCE_EN_BIT]) begin
         tout_d = ctrl_q[fpio_pkg::FPIO_FORCE_LEVEL_BIT];
      end else begin
         case (out_src)
            fpio_pkg::FPIO_SRC_TRIGGER: tout_d = comb_trig;
            fpio_pkg::FPIO_SRC_BOARD_PROBE: tout_d = probe_val;
            fpio_pkg::FPIO_SRC_CHAN_PROBE: tout_d = probes.chan_probe;
            fpio_pkg::FPIO_SRC_SYNC_IN: tout_d = probes.sync_input;
            default: tout_d = 1'b0;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tout_q <= 1'b0;
      end else begin
         tout_q <= tout_d;
      end
   end

   assign trigger_output = tout_q;
   assign trigger_output_oe_n = ctrl_q[fpio_pkg::FPIO_TRIG_OUT_HIZ_BIT];
   // the DAC code is held even when another monitor mode is active
   assign monitor_dac_code = dac_q;
   assign monitor_dac_en = monitor_mode == fpio_pkg::FPIO_MON_VOLT_LEVEL;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   chk_pin_drive_gate: assert property (!reg_mode && sig_cfg != fpio_pkg::FPIO_SIG_PROGRAMMED
      |-> diff_oe_n == '1)
      else $error("pins driven outside register or programmed mode");
   chk_new_mode_gate: assert property (ctrl_q[8] && new_cfg_mode != 4'h0 |-> diff_oe_n == '1)
      else $error("pins driven under new features without register mode");
   chk_group_dir: assert property (reg_req.wr && sel_ctrl && reg_req.wdata[8:2] == 7'h01
      |=> diff_oe_n == {{(NUM_PINS-GROUP_SIZE){1'b1}}, {GROUP_SIZE{1'b0}}})
      else $error("first group not the only driven group");
   chk_trig_hiz: assert property (reg_req.wr && sel_ctrl |=> trigger_output_oe_n == $past(reg_req.wdata[1]))
      else $error("trigger output enable does not follow write");
   chk_force_level: assert property (ctrl_q[15] && $stable(ctrl_q) |=> trigger_output == $past(ctrl_q[14]))
      else $error("forced trigger output level wrong");
   chk_edge_pulse: assert property (ctrl_q[11:10] == 2'b00 && $stable(ctrl_q[11:10])
      && trigger_input && !trig_prev_q |=> board_trig ##1 !board_trig)
      else $error("edge mode did not give a single pulse");
   chk_direct_trig: assert property (ctrl_q[11] |-> board_trig == trigger_input)
      else $error("direct trigger path not transparent");
   chk_reserved_zero: assert property (reg_req.wr && sel_ctrl ##1 reg_req.rd && sel_ctrl && !reg_req.wr
      |=> reg_rsp.ack && reg_rsp.data[31:23] == 9'h000 && reg_rsp.data[13:12] == 2'h0)
      else $error("reserved control bits read nonzero");
   chk_pattern_latch: assert property (ctrl_q[9] && ext_trig_arrive && ctrl_q[22:21] == 2'h0
      |=> pattern == $past(diff_in))
      else $error("pattern not latched on external trigger");
   chk_or_combine: assert property (ctrl_q[17:15] == 3'h0 && out_logic == 2'h0 && |(pair_trig_req & out_mask)
      |=> trigger_output)
      else $error("OR of enabled pair requests not on trigger output");
   chk_dac_mode: assert property (reg_req.wr && sel_dac
      |=> monitor_dac_code == $past(reg_req.wdata[11:0]))
      else $error("monitor not following DAC code");

   cov_reg_mode_drive: cover property (reg_mode && diff_oe_n != '1);
   cov_pattern_latch: cover property (gtrig_to_chan && !ctrl_q[9] ##1 pattern != '0);
   cov_majority: cover property (out_logic == 2'h2 ##1 trigger_output);
   cov_run_probe: cover property (ctrl_q[19:16] == 4'h1 && $rose(run_q) ##1 trigger_output);

endmodule

`default_nettype wire

// [hw/fpio_pkg.sv]
// Purpose: shared constants and carrier types for the front-panel I/O control block
// Assumes: 32-bit registers reached by a simple word-wide register port
// Notes: offsets are byte addresses within the board register space
package fpio_pkg;

   // register offsets
   localparam logic [15:0] FPIO_DIFF_PIN_LEVEL_OFS = 16'h8118;
   localparam logic [15:0] FPIO_FRONT_PANEL_IO_CTRL_OFS = 16'h811c;
   localparam logic [15:0] FPIO_MONITOR_DAC_LEVEL_OFS = 16'h8138;

   // reset values and writable bits
   localparam logic [31:0] FPIO_CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] FPIO_CTRL_WMASK = 32'h007f_cfff;
   localparam logic [15:0] FPIO_PIN_RESET = 16'h0000;
   localparam logic [11:0] FPIO_DAC_RESET = 12'h000;

   // control field positions
   localparam int FPIO_LEVEL_TTL_BIT = 0;
   localparam int FPIO_TRIG_OUT_HIZ_BIT = 1;
   localparam int FPIO_DIR_LSB = 2;
   localparam int FPIO_SIG_CFG_LSB = 6;
   localparam int FPIO_NEW_FEAT_BIT = 8;
   localparam int FPIO_LATCH_EXT_BIT = 9;
   localparam int FPIO_TRIG_LEVEL_BIT = 10;
   localparam int FPIO_TRIG_DIRECT_BIT = 11;
   localparam int FPIO_FORCE_LEVEL_BIT = 14;
   localparam int FPIO_FORCE_EN_BIT = 15;
   localparam int FPIO_OUT_SRC_LSB = 16;
   localparam int FPIO_PROBE_LSB = 18;
   localparam int FPIO_PROBE_ALT_BIT = 20;
   localparam int FPIO_PAT_CFG_LSB = 21;

   // encodings
   localparam logic [1:0] FPIO_SIG_GENERAL = 2'h0;
   localparam logic [1:0] FPIO_SIG_PROGRAMMED = 2'h1;
   localparam logic [1:0] FPIO_SIG_PATTERN = 2'h2;
   localparam logic [3:0] FPIO_NEW_REGISTER_MODE = 4'h0;
   localparam logic [1:0] FPIO_SRC_TRIGGER = 2'h0;
   localparam logic [1:0] FPIO_SRC_BOARD_PROBE = 2'h1;
   localparam logic [1:0] FPIO_SRC_CHAN_PROBE = 2'h2;
   localparam logic [1:0] FPIO_SRC_SYNC_IN = 2'h3;
   localparam logic [1:0] FPIO_PROBE_RUN = 2'h0;
   localparam logic [1:0] FPIO_PROBE_SCLK = 2'h1;
   localparam logic [1:0] FPIO_PROBE_PHASE = 2'h2;
   localparam logic [1:0] FPIO_PROBE_BUSY = 2'h3;
   localparam logic [1:0] FPIO_LOGIC_OR = 2'h0;
   localparam logic [1:0] FPIO_LOGIC_AND = 2'h1;
   localparam logic [1:0] FPIO_LOGIC_MAJ = 2'h2;
   localparam logic [1:0] FPIO_PAT_PINS = 2'h0;
   localparam logic [2:0] FPIO_MON_VOLT_LEVEL = 3'h4;
   localparam int FPIO_DAC_STEP_UV = 244;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [31:0] wdata;
   } fpio_reg_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] data;
   } fpio_reg_rsp_t;

   typedef struct packed {
      logic run;
      logic delayed_run;
      logic sampling_clock;
      logic clock_phase;
      logic busy;
      logic pll_lock_loss;
      logic chan_probe;
      logic sync_input;
   } fpio_probe_t;

endpackage
